/* dv/tpg_pin_model.sv */
// board side of one port: external drivers, pull-ups and floating lines
`timescale 1ns/100ps
module tpg_pin_model #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe_n,
  input wire logic [W-1:0] pullUp,
  input wire logic [W-1:0] extEn,
  input wire logic [W-1:0] extVal,
  output logic [W-1:0] level
);
  logic [W-1:0] floatVal = '0;

  // an undriven line toggles, so a stale value never passes for a drive
  always_ff @(posedge clk) begin
    floatVal <= ~floatVal;
  end

  // wire level: device drive wins, then board driver, pull-up, float
  always_comb begin
    level = (~pinOe_n & pinOut)
      | (pinOe_n & extEn & extVal)
      | (pinOe_n & ~extEn & pullUp)
      | (pinOe_n & ~extEn & ~pullUp & floatVal);
  end
endmodule : tpg_pin_model

/* dv/tpg_tb.sv */
// self-checking testbench for the three-port gpio block
`timescale 1ns/100ps
module tb;
  import tpg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [TPG_AW-1:0] addr = '0;
  logic [TPG_DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [TPG_DW-1:0] rdata;
  logic nonMuxMode = 1'b0;
  logic [7:0] lowAddr = 8'h00;
  logic extAccess;
  logic [4:0] subsysEn = '0;
  logic [4:0] subsysDir = '0;
  logic [4:0] subsysOut = '0;
  logic chipSelEn = 1'b0;
  logic firstChipSelect_n = 1'b1;
  logic [5:0] portBIn, portBOut, portBOe_n;
  logic [3:0] portCIn, portCOut, portCOe_n;
  logic [7:0] portDIn, portDOut, portDOe_n, portDPullUp;
  logic keyboardIrq;
  logic [5:0] extEnB = 6'h3F;
  logic [5:0] extB = 6'h00;
  logic [3:0] extEnC = 4'hF;
  logic [3:0] extC = 4'h0;
  logic [7:0] extEnD = 8'hFF;
  logic [7:0] extD = 8'hF0;
  int n_mismatch = 0;
  int tests_run = 0;

  tpg_gpio DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .nonMuxMode(nonMuxMode), .lowAddr(lowAddr),
    .extAccess(extAccess), .subsysEn(subsysEn), .subsysDir(subsysDir),
    .subsysOut(subsysOut), .chipSelEn(chipSelEn),
    .firstChipSelect_n(firstChipSelect_n), .portBIn(portBIn),
    .portBOut(portBOut), .portBOe_n(portBOe_n), .portCIn(portCIn),
    .portCOut(portCOut), .portCOe_n(portCOe_n), .portDIn(portDIn),
    .portDOut(portDOut), .portDOe_n(portDOe_n), .portDPullUp(portDPullUp),
    .keyboardIrq(keyboardIrq));
  tpg_pin_model #(.W(6)) mB (.clk(clk), .pinOut(portBOut),
    .pinOe_n(portBOe_n), .pullUp(6'h00), .extEn(extEnB), .extVal(extB),
    .level(portBIn));
  tpg_pin_model #(.W(4)) mC (.clk(clk), .pinOut(portCOut),
    .pinOe_n(portCOe_n), .pullUp(4'h0), .extEn(extEnC), .extVal(extC),
    .level(portCIn));
  tpg_pin_model #(.W(8)) mD (.clk(clk), .pinOut(portDOut),
    .pinOe_n(portDOe_n), .pullUp(portDPullUp), .extEn(extEnD),
    .extVal(extD), .level(portDIn));

  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("read %0h", a), exp, rdata);
  endtask : chk_rd

  task automatic hold_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(1);
  endtask : hold_reset

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_rd(TPG_ADDR_B_DIR, 8'h00);
    chk_rd(TPG_ADDR_C_DIR, 8'h00);
    chk_rd(TPG_ADDR_D_DIR, 8'h00);
    chk_rd(TPG_ADDR_KEY_CTRL, 8'h00);
    chk_rd(5'h1F, 8'h00);
    chk("oeB", 8'h3F, {2'h0, portBOe_n});
    chk("oeD", 8'hFF, portDOe_n);
    $display("test reset done");
  endtask : t_reset

  // data first, then direction for the mixed case; the all-output case writes direction 0F before data 09
  task automatic t_port_c();
    extC <= 4'h5;
    reg_wr(TPG_ADDR_C_DATA, 8'h0F);
    tick(3);
    chk("oeC in", 8'h0F, {4'h0, portCOe_n});
    chk_rd(TPG_ADDR_C_DATA, 8'h05);
    reg_wr(TPG_ADDR_C_DIR, 8'h03);
    extC <= 4'hA;
    tick(3);
    chk("oeC mix", 8'h0C, {4'h0, portCOe_n});
    chk("outC", 8'h03, {4'h0, portCOut & 4'h3});
    chk_rd(TPG_ADDR_C_DATA, 8'h0B);
    chk_rd(TPG_ADDR_C_DIR, 8'h03);
    reg_wr(TPG_ADDR_C_DATA, 8'h00);
    tick(2);
    chk("outC new", 8'h00, {4'h0, portCOut & 4'h3});
    reg_wr(TPG_ADDR_C_DIR, 8'h0F);
    reg_wr(TPG_ADDR_C_DATA, 8'h09);
    tick(2);
    chk("outC all", 8'h09, {4'h0, portCOut});
    chk("oeC out", 8'h00, {4'h0, portCOe_n});
    chk_rd(TPG_ADDR_C_DATA, 8'h09);
    $display("test port c done");
  endtask : t_port_c

  task automatic t_dir_width();
    reg_wr(TPG_ADDR_B_DIR, 8'hFF);
    chk_rd(TPG_ADDR_B_DIR, 8'h3F);
    reg_wr(TPG_ADDR_D_DIR, 8'hA5);
    chk_rd(TPG_ADDR_D_DIR, 8'hA5);
    reg_wr(TPG_ADDR_B_DIR, 8'h00);
    reg_wr(TPG_ADDR_D_DIR, 8'h00);
    $display("test direction width done");
  endtask : t_dir_width

  task automatic t_subsys();
    subsysEn <= 5'h01;
    subsysDir <= 5'h01;
    subsysOut <= 5'h01;
    chipSelEn <= 1'b1;
    firstChipSelect_n <= 1'b0;
    extB <= 6'h2A;
    tick(4);
    chk("oeB sub", 8'h1E, {2'h0, portBOe_n});
    chk("outB sub", 8'h01, {2'h0, portBOut & 6'h21});
    chk_rd(TPG_ADDR_B_DATA, 8'h0B);
    reg_wr(TPG_ADDR_B_DATA, 8'h00);
    reg_wr(TPG_ADDR_B_DIR, 8'h01);
    tick(2);
    chk_rd(TPG_ADDR_B_DATA, 8'h0A);
    chk("outB own", 8'h01, {7'h0, portBOut[0]});
    @(posedge clk);
    subsysEn <= 5'h00;
    chipSelEn <= 1'b0;
    $display("test shared lines done");
  endtask : t_subsys

  task automatic t_reset_latch();
    reg_wr(TPG_ADDR_D_DATA, 8'h5A);
    reg_wr(TPG_ADDR_D_DIR, 8'hFF);
    tick(2);
    chk("outD", 8'h5A, portDOut);
    hold_reset();
    chk("oeD rst", 8'hFF, portDOe_n);
    chk_rd(TPG_ADDR_D_DIR, 8'h00);
    reg_wr(TPG_ADDR_D_DIR, 8'hFF);
    tick(2);
    chk("outD kept", 8'h5A, portDOut);
    $display("test reset keeps latch done");
  endtask : t_reset_latch

  task automatic t_keyboard();
    reg_wr(TPG_ADDR_D_DATA, 8'h00);
    reg_wr(TPG_ADDR_D_DIR, 8'h0F);
    reg_wr(TPG_ADDR_KEY_CTRL, 8'h40);
    tick(3);
    chk("pull", 8'hF0, portDPullUp);
    extEnD <= 8'h80;
    extD <= 8'h80;
    tick(4);
    chk("irq idle", 8'h00, {7'h0, keyboardIrq});
    chk_rd(TPG_ADDR_KEY_CTRL, 8'h40);
    extD <= 8'h00;
    for (int i = 0; i < 8 && keyboardIrq !== 1'b1; i++) tick(1);
    chk("irq", 8'h01, {7'h0, keyboardIrq});
    chk_rd(TPG_ADDR_KEY_CTRL, 8'hC0);
    reg_wr(TPG_ADDR_KEY_CTRL, 8'h60);
    tick(3);
    chk("irq ack", 8'h00, {7'h0, keyboardIrq});
    chk_rd(TPG_ADDR_KEY_CTRL, 8'h40);
    reg_wr(TPG_ADDR_KEY_CTRL, 8'h50);
    chk_rd(TPG_ADDR_KEY_CTRL, 8'h40);
    // level mode: a line held low keeps the flag through an acknowledge
    hold_reset();
    reg_wr(TPG_ADDR_KEY_CTRL, 8'h50);
    tick(4);
    chk_rd(TPG_ADDR_KEY_CTRL, 8'hD0);
    reg_wr(TPG_ADDR_KEY_CTRL, 8'h70);
    tick(3);
    chk_rd(TPG_ADDR_KEY_CTRL, 8'hD0);
    reg_wr(TPG_ADDR_KEY_CTRL, 8'h00);
    $display("test keyboard done");
  endtask : t_keyboard

  task automatic t_non_mux();
    reg_wr(TPG_ADDR_D_DIR, 8'h3C);
    nonMuxMode <= 1'b1;
    lowAddr <= 8'hC3;
    tick(3);
    chk("oeD nm", 8'h00, portDOe_n);
    chk("outD nm", 8'hC3, portDOut);
    reg_wr(TPG_ADDR_D_DIR, 8'hFF);
    #1;
    chk("ext wr", 8'h01, {7'h0, extAccess});
    reg_wr(TPG_ADDR_D_DATA, 8'hFF);
    chk_rd(TPG_ADDR_D_DATA, 8'h00);
    chk("ext rd", 8'h01, {7'h0, extAccess});
    @(posedge clk);
    nonMuxMode <= 1'b0;
    tick(2);
    chk_rd(TPG_ADDR_D_DIR, 8'h3C);
    chk("outD back", 8'h00, portDOut & 8'h3C);
    $display("test non-multiplexed done");
  endtask : t_non_mux

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_port_c();
    t_dir_width();
    t_subsys();
    t_reset_latch();
    t_keyboard();
    t_non_mux();
    end_sim();
  end

  // the tests take well under a thousand cycles
  initial begin
    #(50 * 5000);
    n_mismatch++;
    end_sim();
  end
endmodule : tb

/* inc/tpg_pkg.sv */
// package: register map, field layout and sizes of the three-port gpio block
package tpg_pkg;

  localparam int TPG_AW = 5;
  localparam int TPG_DW = 8;

  // register offsets (byte addresses on the local register port)
  localparam logic [4:0] TPG_ADDR_B_DATA = 5'h01;
  localparam logic [4:0] TPG_ADDR_C_DATA = 5'h02;
  localparam logic [4:0] TPG_ADDR_D_DATA = 5'h03;
  localparam logic [4:0] TPG_ADDR_B_DIR = 5'h05;
  localparam logic [4:0] TPG_ADDR_C_DIR = 5'h06;
  localparam logic [4:0] TPG_ADDR_D_DIR = 5'h07;
  localparam logic [4:0] TPG_ADDR_KEY_CTRL = 5'h1A;

  // port widths
  localparam int TPG_B_W = 6;
  localparam int TPG_C_W = 4;
  localparam int TPG_D_W = 8;

  // keyboard control/status field positions
  localparam int TPG_KEY_FLAG_BIT = 7;
  localparam int TPG_KEY_EN_BIT = 6;
  localparam int TPG_KEY_ACK_BIT = 5;
  localparam int TPG_KEY_SEL_BIT = 4;

  // reset values
  localparam logic [7:0] TPG_DIR_RST = 8'h00;
  localparam logic [7:0] TPG_ZERO8 = 8'h00;

endpackage : tpg_pkg

/* logic/tpg_gpio.sv */
// three-port gpio with keyboard wake-up on port d
`timescale 1ns/100ps
module tpg_gpio
  import tpg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [TPG_AW-1:0] addr,
  input wire logic [TPG_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [TPG_DW-1:0] rdata,
  input wire logic nonMuxMode,
  input wire logic [TPG_D_W-1:0] lowAddr,
  output logic extAccess,
  input wire logic [TPG_B_W-2:0] subsysEn,
  input wire logic [TPG_B_W-2:0] subsysDir,
  input wire logic [TPG_B_W-2:0] subsysOut,
  input wire logic chipSelEn,
  input wire logic firstChipSelect_n,
  input wire logic [TPG_B_W-1:0] portBIn,
  output logic [TPG_B_W-1:0] portBOut,
  output logic [TPG_B_W-1:0] portBOe_n,
  input wire logic [TPG_C_W-1:0] portCIn,
  output logic [TPG_C_W-1:0] portCOut,
  output logic [TPG_C_W-1:0] portCOe_n,
  input wire logic [TPG_D_W-1:0] portDIn,
  output logic [TPG_D_W-1:0] portDOut,
  output logic [TPG_D_W-1:0] portDOe_n,
  output logic [TPG_D_W-1:0] portDPullUp,
  output logic keyboardIrq
);

  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  function automatic logic hit(input logic [TPG_AW-1:0] a,
                               input logic [TPG_AW-1:0] target);
    hit = (a == target);
  endfunction : hit

  logic portDExternal;
  logic wrBData, wrBDir, wrCData, wrCDir, wrDData, wrDDir, wrKey;

  // port d addresses leave the block while the pins carry address
  always_comb begin
    portDExternal = nonMuxMode;
    wrBData = wr && hit(addr, TPG_ADDR_B_DATA);
    wrBDir = wr && hit(addr, TPG_ADDR_B_DIR);
    wrCData = wr && hit(addr, TPG_ADDR_C_DATA);
    wrCDir = wr && hit(addr, TPG_ADDR_C_DIR);
    wrDData = wr && hit(addr, TPG_ADDR_D_DATA) && !portDExternal;
    wrDDir = wr && hit(addr, TPG_ADDR_D_DIR) && !portDExternal;
    wrKey = wr && hit(addr, TPG_ADDR_KEY_CTRL);
  end

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [TPG_B_W-1:0] syncB;
  logic [TPG_C_W-1:0] syncC;
  logic [TPG_D_W-1:0] syncD;

  // pins come from the board, so two stages before any use
  tpg_sync #(.W(TPG_B_W)) u_sync_b (.clk(clk), .async(portBIn),
    .synced(syncB));
  tpg_sync #(.W(TPG_C_W)) u_sync_c (.clk(clk), .async(portCIn),
    .synced(syncC));
  tpg_sync #(.W(TPG_D_W)) u_sync_d (.clk(clk), .async(portDIn),
    .synced(syncD));

  // -------------------------------------------------------------
  // ports
  // -------------------------------------------------------------
  logic [TPG_B_W-1:0] latchB, dirB, readB, driveB, bSubEn, bSubDir;
  logic [TPG_C_W-1:0] latchC, dirC, readC, driveC;
  logic [TPG_D_W-1:0] latchD, dirD, readD, driveD;

  // low bits go to timer/serial, top bit to the chip select
  always_comb begin
    bSubEn = {chipSelEn, subsysEn};
    bSubDir = {1'b1, subsysDir};
  end

  tpg_port #(.W(TPG_B_W)) u_port_b (
    .clk(clk), .rst(rst), .writeData(wrBData), .writeDir(wrBDir),
    .wdata(wdata[TPG_B_W-1:0]), .pinLevel(syncB), .subsysEn(bSubEn),
    .subsysDir(bSubDir), .latch(latchB), .dir(dirB), .readValue(readB),
    .driveOn(driveB));

  tpg_port #(.W(TPG_C_W)) u_port_c (
    .clk(clk), .rst(rst), .writeData(wrCData), .writeDir(wrCDir),
    .wdata(wdata[TPG_C_W-1:0]), .pinLevel(syncC),
    .subsysEn({TPG_C_W{1'b0}}), .subsysDir({TPG_C_W{1'b0}}),
    .latch(latchC), .dir(dirC), .readValue(readC), .driveOn(driveC));

  tpg_port #(.W(TPG_D_W)) u_port_d (
    .clk(clk), .rst(rst), .writeData(wrDData), .writeDir(wrDDir),
    .wdata(wdata[TPG_D_W-1:0]), .pinLevel(syncD),
    .subsysEn({TPG_D_W{1'b0}}), .subsysDir({TPG_D_W{1'b0}}),
    .latch(latchD), .dir(dirD), .readValue(readD), .driveOn(driveD));

  // -------------------------------------------------------------
  // keyboard scan control and detection
  // -------------------------------------------------------------
  logic keyboardScanEnable;
  logic keyboardTriggerSelect;
  logic triggerLocked;
  logic keyboardRequestFlag;
  logic scanLatch;
  logic keyboardAcknowledge;
  logic [TPG_D_W-1:0] lowPrev;
  logic [TPG_D_W-1:0] lowNow;
  logic anyLow, anyFall;

  // only input lines in gpio mode take part in scanning
  always_comb begin
    lowNow = ~syncD & ~dirD & {TPG_D_W{!portDExternal}};
    anyLow = keyboardScanEnable && (lowNow != TPG_ZERO8);
    anyFall = keyboardScanEnable && ((lowNow & ~lowPrev) != TPG_ZERO8);
    keyboardAcknowledge = wrKey && wdata[TPG_KEY_ACK_BIT];
  end

  // previous low pattern for falling-edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      lowPrev <= TPG_ZERO8;
    end else begin
      lowPrev <= lowNow;
    end
  end

  // enable is freely writable
  always_ff @(posedge clk) begin
    if (rst) begin
      keyboardScanEnable <= 1'b0;
    end else if (wrKey) begin
      keyboardScanEnable <= wdata[TPG_KEY_EN_BIT];
    end
  end

  // trigger select takes the first write after reset and then locks
  always_ff @(posedge clk) begin
    if (rst) begin
      keyboardTriggerSelect <= 1'b0;
      triggerLocked <= 1'b0;
    end else if (wrKey && !triggerLocked) begin
      keyboardTriggerSelect <= wdata[TPG_KEY_SEL_BIT];
      triggerLocked <= 1'b1;
    end
  end

  // scan latch catches falling edges; a new edge beats the acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      scanLatch <= 1'b0;
    end else if (anyFall) begin
      scanLatch <= 1'b1;
    end else if (keyboardAcknowledge) begin
      scanLatch <= 1'b0;
    end
  end

  // level mode keeps requesting while a key is held down
  always_ff @(posedge clk) begin
    if (rst) begin
      keyboardRequestFlag <= 1'b0;
    end else if (anyFall || (keyboardTriggerSelect && anyLow)) begin
      keyboardRequestFlag <= 1'b1;
    end else if (keyboardAcknowledge && !keyboardTriggerSelect) begin
      keyboardRequestFlag <= 1'b0;
    end else if (keyboardTriggerSelect && !scanLatch && !anyLow) begin
      keyboardRequestFlag <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------
  logic [TPG_B_W-1:0] outB;

  // chip select takes the top bit, other subsystems their own bits
  always_comb begin
    outB = latchB;
    for (int i = 0; i < TPG_B_W - 1; i++) begin
      if (subsysEn[i]) begin
        outB[i] = subsysOut[i];
      end
    end
    if (chipSelEn) begin
      outB[TPG_B_W-1] = firstChipSelect_n;
    end
  end

  // pins register one cycle after the latch or direction update
  always_ff @(posedge clk) begin
    if (rst) begin
      portBOe_n <= {TPG_B_W{1'b1}};
      portCOe_n <= {TPG_C_W{1'b1}};
      portDOe_n <= {TPG_D_W{1'b1}};
      portBOut <= {TPG_B_W{1'b0}};
      portCOut <= {TPG_C_W{1'b0}};
      portDOut <= TPG_ZERO8;
      portDPullUp <= TPG_ZERO8;
      keyboardIrq <= 1'b0;
    end else begin
      portBOe_n <= ~driveB;
      portCOe_n <= ~driveC;
      portDOe_n <= portDExternal ? TPG_ZERO8 : ~driveD;
      portBOut <= outB;
      portCOut <= latchC;
      portDOut <= portDExternal ? lowAddr : latchD;
      portDPullUp <= (keyboardScanEnable && !portDExternal) ?
        ~dirD : TPG_ZERO8;
      keyboardIrq <= keyboardRequestFlag;
    end
  end

  // -------------------------------------------------------------
  // register read port
  // -------------------------------------------------------------
  logic [TPG_DW-1:0] next_rdata;
  logic next_extAccess;

  // unmapped addresses read as zero
  always_comb begin
    next_rdata = TPG_ZERO8;
    next_extAccess = 1'b0;
    case (addr)
      TPG_ADDR_B_DATA: next_rdata = {2'h0, readB};
      TPG_ADDR_C_DATA: next_rdata = {4'h0, readC};
      TPG_ADDR_D_DATA: next_rdata = portDExternal ? TPG_ZERO8 : readD;
      TPG_ADDR_B_DIR: next_rdata = {2'h0, dirB};
      TPG_ADDR_C_DIR: next_rdata = {4'h0, dirC};
      TPG_ADDR_D_DIR: next_rdata = portDExternal ? TPG_ZERO8 : dirD;
      TPG_ADDR_KEY_CTRL: begin
        next_rdata[TPG_KEY_FLAG_BIT] = keyboardRequestFlag;
        next_rdata[TPG_KEY_EN_BIT] = keyboardScanEnable;
        next_rdata[TPG_KEY_SEL_BIT] = keyboardTriggerSelect;
      end
      default: next_rdata = TPG_ZERO8;
    endcase
    if ((hit(addr, TPG_ADDR_D_DATA) || hit(addr, TPG_ADDR_D_DIR)) &&
        portDExternal && (rd || wr)) begin
      next_extAccess = 1'b1;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= TPG_ZERO8;
      extAccess <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : TPG_ZERO8;
      extAccess <= next_extAccess;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_dir_reset;
    @(posedge clk) rst |=> (dirB == TPG_DIR_RST[TPG_B_W-1:0]) &&
      (dirD == TPG_DIR_RST);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction not cleared by reset");

  property p_latch_kept;
    @(posedge clk) (rst && !wrCData) |=> $stable(latchC);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("data latch changed by reset");

  property p_out_follows;
    @(posedge clk) disable iff (rst)
      (wrCData && dirC == {TPG_C_W{1'b1}} && !wrCDir) |=> ##1
      (portCOut == $past(wdata[TPG_C_W-1:0], 2)) && (portCOe_n == '0);
  endproperty
  a_out_follows: assert property (p_out_follows)
    else $error("output pin missed written value");

  property p_input_quiet;
    @(posedge clk) disable iff (rst)
      (dirC == '0 && !wrCDir) |=> portCOe_n == {TPG_C_W{1'b1}};
  endproperty
  a_input_quiet: assert property (p_input_quiet)
    else $error("input line driven");

  property p_read_mux;
    @(posedge clk) disable iff (rst)
      (rd && hit(addr, TPG_ADDR_C_DATA)) |=>
      rdata[TPG_C_W-1:0] == $past((dirC & latchC) | (~dirC & syncC));
  endproperty
  a_read_mux: assert property (p_read_mux)
    else $error("data read mux wrong");

  // write, one idle cycle, then read of the same direction register
  sequence s_dir_b_write;
    wr && hit(addr, TPG_ADDR_B_DIR);
  endsequence

  sequence s_dir_b_read;
    rd && hit(addr, TPG_ADDR_B_DIR);
  endsequence

  property p_dir_readback;
    @(posedge clk) disable iff (rst)
      s_dir_b_write ##1 !wr ##1 s_dir_b_read |=>
      rdata[TPG_B_W-1:0] == $past(wdata[TPG_B_W-1:0], 3);
  endproperty
  a_dir_readback: assert property (p_dir_readback)
    else $error("direction readback wrong");

  property p_sel_locked;
    @(posedge clk) disable iff (rst)
      triggerLocked |=> $stable(keyboardTriggerSelect);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("trigger select rewritten");

  property p_ack_clears;
    @(posedge clk) disable iff (rst)
      (keyboardAcknowledge && !keyboardTriggerSelect && !anyFall) |=>
      !keyboardRequestFlag ##1 !keyboardIrq;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge did not clear request");

  property p_ext_port_d;
    @(posedge clk) disable iff (rst)
      (nonMuxMode && wr && hit(addr, TPG_ADDR_D_DATA)) |=>
      extAccess && $stable(latchD);
  endproperty
  a_ext_port_d: assert property (p_ext_port_d)
    else $error("port d access not forwarded");

  property p_pullup_outputs;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (portDPullUp & $past(dirD)) == TPG_ZERO8;
  endproperty
  a_pullup_outputs: assert property (p_pullup_outputs)
    else $error("pull-up on output line");

endmodule : tpg_gpio

/* logic/tpg_port.sv */
// one bidirectional port: latch, direction register, read mux
`timescale 1ns/100ps
module tpg_port
  import tpg_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic writeData,
  input wire logic writeDir,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] pinLevel,
  input wire logic [W-1:0] subsysEn,
  input wire logic [W-1:0] subsysDir,
  output logic [W-1:0] latch,
  output logic [W-1:0] dir,
  output logic [W-1:0] readValue,
  output logic [W-1:0] driveOn
);

  // data latch has no reset: its content survives reset
  always_ff @(posedge clk) begin
    if (writeData) begin
      latch <= wdata;
    end
  end

  // direction register clears on reset, making every line no subsystem owns an input
  always_ff @(posedge clk) begin
    if (rst) begin
      dir <= TPG_DIR_RST[W-1:0];
    end else if (writeDir) begin
      dir <= wdata;
    end
  end

  // direction bit picks latch or pin even for lines a subsystem owns
  always_comb begin
    readValue = (dir & latch) | (~dir & pinLevel);
    driveOn = (subsysEn & subsysDir) | (~subsysEn & dir);
  end

endmodule : tpg_port

/* logic/tpg_sync.sv */
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/100ps
module tpg_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  logic [W-1:0] meta;

  // first stage feeds the second stage only
  always_ff @(posedge clk) begin
    meta <= async;
    synced <= meta;
  end

endmodule : tpg_sync
